// *** include/spd_pkg.sv ***
package spd_pkg;

  // reference clock and self-timed programming cycle
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WR_TIME_NS = 5_000_000;
  // longest time, so the count rounds down
  localparam int unsigned WR_CYCLE_COUNT = WR_TIME_NS / CLK_PERIOD_NS;
  localparam int WR_CNT_W = 20;

  // array geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W = 4;
  localparam int LOCK_HALF_BIT = 3;

  // slave address fields
  localparam logic [3:0] MEM_TYPE_CODE = 4'h9;
  localparam logic [3:0] PROT_TYPE_CODE = 4'h6;
  localparam logic [2:0] SEL_SET_REV = 3'h1;
  localparam logic [2:0] SEL_CLR_REV = 3'h3;

  // rising-edge counter positions within one nine-clock frame
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ACK_SLOT = 4'h8;
  localparam logic [3:0] CNT_ACK_DONE = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA,
    ST_DONE
  } spd_state_e;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_MEM,
    CMD_SET_REV,
    CMD_CLR_REV,
    CMD_SET_PERM
  } spd_cmd_e;

  typedef struct packed {
    logic ack;
    logic rd;
    spd_cmd_e cmd;
  } spd_decode_s;

  // pins as seen after the two-flop synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic lock;
    logic [2:0] sel;
  } spd_pins_s;

endpackage

// *** hw/spd_eeprom_slave.sv ***
`timescale 1ns/1ns
// Functional notes
// [RULE1] data line only pulled low or released
// [RULE2] unconnected select inputs read as zero
// [RULE3] lock input high refuses all array writes
// [RULE4] protected lower half stays read-only
// [RULE5] eight bits per byte, msb first
// [RULE6] change on clock low, sample clock high
// [RULE7] start is sda falling, scl high
// [RULE8] stop is sda rising, scl high
// [RULE9] receiver acknowledges low on ninth clock
// [RULE10] master may clock nine times, then start
// [RULE11] start resets interface, drops partial transfer
// [RULE12] ignore bus until reset released, standby
// [RULE13] standby after stop or write cycle end
// [RULE14] upper nibble equals memory type code
// [RULE15] nibble 0110 selects protection command
// [RULE16] select bits compared with select pins
// [RULE17] last address bit: one read, zero write
// [RULE18] matching address acknowledged low
// [RULE19] 0110 select 001: set/read reversible
// [RULE20] 0110 select 011: clear/read clear status
// [RULE21] 0110 matching pins: permanent set/read
// [RULE22] 256 bytes, sixteen-byte pages, partial pages
// [RULE23] page write wraps low four bits
// [RULE24] no address acknowledge while write busy
// [RULE25] write cycle timer starts at stop
module spd_eeprom_slave #(
  parameter int unsigned WR_CYCLES = spd_pkg::WR_CYCLE_COUNT
) (
  input logic ref_clk,
  input logic rst_n,
  input logic link_clk,
  input logic scl_i,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input logic select_input_bit0,
  input logic select_input_bit1,
  input logic select_input_bit2,
  input logic lock_i,
  output logic standby,
  output logic write_busy,
  output logic rev_prot,
  output logic perm_prot
);
  import spd_pkg::*;

  function automatic spd_decode_s decode_addr(
    input logic [7:0] b,
    input logic [2:0] pins,
    input logic busy,
    input logic lock,
    input logic rev,
    input logic perm
  );
    spd_decode_s d;
    d.ack = 1'b0;
    d.rd = b[0]; // [RULE17]
    d.cmd = CMD_NONE;
    if (!busy) begin // [RULE24]
      if (b[7:4] == MEM_TYPE_CODE && b[3:1] == pins) begin // [RULE14] [RULE16]
        d.ack = 1'b1; // [RULE18]
        d.cmd = CMD_MEM;
      end else if (b[7:4] == PROT_TYPE_CODE) begin // [RULE15]
        if (b[3:1] == SEL_SET_REV) begin // [RULE19]
          d.cmd = CMD_SET_REV;
          d.ack = b[0] ? !rev : (!lock && !perm);
        end else if (b[3:1] == SEL_CLR_REV) begin // [RULE20]
          d.cmd = CMD_CLR_REV;
          d.ack = b[0] ? !rev : (!lock && !perm);
        end else if (b[3:1] == pins) begin // [RULE21]
          d.cmd = CMD_SET_PERM;
          d.ack = b[0] ? !perm : !lock;
        end
      end
    end
    return d;
  endfunction

  // ---------------- link domain ----------------
  logic lrst_m_reg;
  logic lrst_n_s_reg;
  spd_pins_s pin_m_reg;
  spd_pins_s pin_s_reg;
  logic scl_p_reg;
  logic sda_p_reg;
  spd_state_e state_reg;
  spd_cmd_e cmd_reg;
  logic [3:0] cnt_reg;
  logic [DATA_W-1:0] rx_reg;
  logic [DATA_W-1:0] tx_reg;
  logic tx_en_reg;
  logic ack_drv_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic [PAGE_W-1:0] pg_base_reg;
  logic [PAGE_BYTES-1:0] pg_valid_reg;
  logic [DATA_W-1:0] pg_data_reg [PAGE_BYTES];
  logic pend_reg;
  logic commit_reg;
  logic [DATA_W-1:0] mem_reg [MEM_DEPTH];
  logic rev_reg;
  logic perm_reg;
  logic wr_tgl_reg;
  logic wait_reg;
  logic busy_m_reg;
  logic busy_s_reg;
  logic standby_reg;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic busy;
  logic write_ok;
  logic prog_go;
  spd_decode_s dec;

  // reset release crossing into the link domain
  always_ff @(posedge link_clk) begin
    lrst_m_reg <= rst_n;
    lrst_n_s_reg <= lrst_m_reg;
  end

  // pins pass two flops before use; select pins float low outside [RULE2]
  always_ff @(posedge link_clk) begin
    pin_m_reg <= '{scl: scl_i, sda: sda_i, lock: lock_i,
                   sel: {select_input_bit2, select_input_bit1, select_input_bit0}};
    pin_s_reg <= pin_m_reg;
    scl_p_reg <= pin_s_reg.scl;
    sda_p_reg <= pin_s_reg.sda;
  end

  assign rise = pin_s_reg.scl && !scl_p_reg;
  assign fall = !pin_s_reg.scl && scl_p_reg;
  assign start_ev = pin_s_reg.scl && scl_p_reg && sda_p_reg && !pin_s_reg.sda; // [RULE7] [RULE6]
  assign stop_ev = pin_s_reg.scl && scl_p_reg && !sda_p_reg && pin_s_reg.sda; // [RULE8] [RULE6]
  assign busy = wait_reg || busy_s_reg;
  assign dec = decode_addr(rx_reg, pin_s_reg.sel, busy, pin_s_reg.lock, rev_reg, perm_reg);

  // protocol engine
  always_ff @(posedge link_clk) begin
    if (!lrst_n_s_reg) begin // [RULE12]
      state_reg <= ST_IDLE;
      cmd_reg <= CMD_NONE;
      cnt_reg <= CNT_ZERO;
      rx_reg <= '0;
      tx_reg <= '0;
      tx_en_reg <= 1'b0;
      ack_drv_reg <= 1'b0;
      ptr_reg <= '0;
      pg_base_reg <= '0;
      pg_valid_reg <= '0;
      pend_reg <= 1'b0;
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= 1'b0;
      if (start_ev) begin // [RULE11]
        state_reg <= ST_ADDR;
        cnt_reg <= CNT_ZERO;
        tx_en_reg <= 1'b0;
        ack_drv_reg <= 1'b0;
        pg_valid_reg <= '0;
        pend_reg <= 1'b0;
      end else if (stop_ev) begin
        commit_reg <= pend_reg; // [RULE25]
        pend_reg <= 1'b0;
        state_reg <= ST_IDLE;
        tx_en_reg <= 1'b0;
        ack_drv_reg <= 1'b0;
      end else if (state_reg != ST_IDLE) begin // [RULE7]
        if (rise) begin
          if (cnt_reg < CNT_ACK_SLOT) begin
            rx_reg <= {rx_reg[DATA_W-2:0], pin_s_reg.sda}; // [RULE5]
          end else if (state_reg == ST_RDATA && pin_s_reg.sda) begin
            state_reg <= ST_IDLE;
          end
          cnt_reg <= cnt_reg + 4'h1;
        end else if (fall) begin
          if (cnt_reg == CNT_ACK_SLOT) begin
            tx_en_reg <= 1'b0;
            case (state_reg)
              ST_ADDR: begin
                ack_drv_reg <= dec.ack; // [RULE18] [RULE24]
                cmd_reg <= dec.cmd;
                if (!dec.ack) begin
                  state_reg <= ST_IDLE;
                end else if (!dec.rd) begin
                  state_reg <= ST_WADDR;
                end else if (dec.cmd == CMD_MEM) begin
                  state_reg <= ST_RDATA;
                end else begin
                  state_reg <= ST_DONE;
                end
              end
              ST_WADDR: begin
                ack_drv_reg <= 1'b1; // [RULE9]
                state_reg <= ST_WDATA;
                if (cmd_reg == CMD_MEM) begin
                  ptr_reg <= rx_reg;
                  pg_base_reg <= rx_reg[ADDR_W-1:PAGE_W];
                end
              end
              ST_WDATA: begin
                ack_drv_reg <= 1'b1; // [RULE9]
                pend_reg <= 1'b1;
                if (cmd_reg == CMD_MEM) begin // [RULE22]
                  pg_data_reg[ptr_reg[PAGE_W-1:0]] <= rx_reg;
                  pg_valid_reg[ptr_reg[PAGE_W-1:0]] <= 1'b1;
                  ptr_reg[PAGE_W-1:0] <= ptr_reg[PAGE_W-1:0] + 4'h1; // [RULE23]
                end
              end
              default: begin
              end
            endcase
          end else if (cnt_reg == CNT_ACK_DONE) begin
            ack_drv_reg <= 1'b0;
            cnt_reg <= CNT_ZERO;
            if (state_reg == ST_RDATA) begin
              tx_reg <= mem_reg[ptr_reg];
              ptr_reg <= ptr_reg + 8'h01;
              tx_en_reg <= 1'b1;
            end else if (state_reg == ST_DONE) begin
              state_reg <= ST_IDLE;
            end
          end else if (cnt_reg != CNT_ZERO && state_reg == ST_RDATA) begin
            tx_reg <= {tx_reg[DATA_W-2:0], 1'b0}; // [RULE5] [RULE6]
          end
        end
      end
    end
  end

  // lower half is refused once either software flag is set
  assign write_ok = !pin_s_reg.lock && (pg_base_reg[LOCK_HALF_BIT] || !(rev_reg || perm_reg)); // [RULE3] [RULE4]

  always_comb begin
    prog_go = 1'b0;
    if (commit_reg && !pin_s_reg.lock) begin
      case (cmd_reg)
        CMD_MEM: prog_go = write_ok;
        CMD_SET_REV: prog_go = !perm_reg;
        CMD_CLR_REV: prog_go = !perm_reg;
        CMD_SET_PERM: prog_go = 1'b1;
        default: prog_go = 1'b0;
      endcase
    end
  end

  // array storage, written one page at the end of a write
  always_ff @(posedge link_clk) begin
    if (prog_go && cmd_reg == CMD_MEM) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pg_valid_reg[i]) begin
          mem_reg[{pg_base_reg, PAGE_W'(i)}] <= pg_data_reg[i];
        end
      end
    end
  end

  // software protection flags
  always_ff @(posedge link_clk) begin
    if (!lrst_n_s_reg) begin
      rev_reg <= 1'b0;
      perm_reg <= 1'b0;
    end else if (prog_go) begin
      case (cmd_reg)
        CMD_SET_REV: rev_reg <= 1'b1; // [RULE19]
        CMD_CLR_REV: rev_reg <= 1'b0; // [RULE20]
        CMD_SET_PERM: perm_reg <= 1'b1; // [RULE21]
        default: begin
        end
      endcase
    end
  end

  // write cycle request toggle and busy tracking
  always_ff @(posedge link_clk) begin
    busy_m_reg <= write_busy;
    busy_s_reg <= busy_m_reg;
    if (!lrst_n_s_reg) begin
      wr_tgl_reg <= 1'b0;
      wait_reg <= 1'b0;
      standby_reg <= 1'b0;
    end else begin
      if (prog_go) begin
        wr_tgl_reg <= !wr_tgl_reg; // [RULE25]
        wait_reg <= 1'b1;
      end else if (busy_s_reg) begin
        wait_reg <= 1'b0;
      end
      standby_reg <= state_reg == ST_IDLE && !busy && !prog_go; // [RULE13]
    end
  end

  assign sda_o = 1'b0; // [RULE1]
  assign sda_oe_n = !(ack_drv_reg || (tx_en_reg && !tx_reg[DATA_W-1])); // [RULE1] [RULE9]
  assign standby = standby_reg;
  assign rev_prot = rev_reg;
  assign perm_prot = perm_reg;

  // ---------------- reference domain: write cycle timer ----------------
  logic tgl_m_reg;
  logic tgl_s_reg;
  logic tgl_p_reg;
  logic busy_ref_reg;
  logic [WR_CNT_W-1:0] wcnt_reg;

  always_ff @(posedge ref_clk) begin
    tgl_m_reg <= wr_tgl_reg;
    tgl_s_reg <= tgl_m_reg;
    tgl_p_reg <= tgl_s_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_ref_reg <= 1'b0;
      wcnt_reg <= '0;
    end else if (tgl_s_reg != tgl_p_reg) begin
      busy_ref_reg <= 1'b1; // [RULE25]
      wcnt_reg <= WR_CNT_W'(WR_CYCLES - 1);
    end else if (busy_ref_reg) begin
      if (wcnt_reg == '0) begin
        busy_ref_reg <= 1'b0; // [RULE13]
      end else begin
        wcnt_reg <= wcnt_reg - 1'b1;
      end
    end
  end

  assign write_busy = busy_ref_reg;

endmodule

// *** dv/spd_slave_properties.sv ***
`timescale 1ns/1ns
module spd_slave_props #(
  parameter int unsigned WR_CYCLES = 50
) (
  input logic ref_clk,
  input logic rst_n,
  input logic link_clk,
  input logic scl_i,
  input logic sda_o,
  input logic sda_oe_n,
  input logic lock_i,
  input logic standby,
  input logic write_busy,
  input logic rev_prot,
  input logic perm_prot
);
  int unsigned busy_cnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !write_busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  sda_pull_only_a: assert property (@(posedge link_clk) disable iff (!rst_n) sda_o == 1'b0)
    else $error("sda driven high");
  busy_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(write_busy) |-> busy_cnt + 1 >= WR_CYCLES && busy_cnt <= WR_CYCLES + 1) else $error("write time off");
  busy_silent_a: assert property (@(posedge link_clk) disable iff (!rst_n) write_busy |-> sda_oe_n)
    else $error("drive while busy");
  busy_not_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n) write_busy |-> !standby)
    else $error("standby while busy");
  idle_silent_a: assert property (@(posedge link_clk) disable iff (!rst_n) standby |-> sda_oe_n)
    else $error("drive while idle");
  drive_scl_low_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    $changed(sda_oe_n) |-> !scl_i) else $error("sda moved with scl high");
  lock_blocks_a: assert property (@(posedge ref_clk) disable iff (!rst_n) $rose(write_busy) |-> !lock_i)
    else $error("write under lock");
  perm_sticky_a: assert property (@(posedge link_clk) disable iff (!rst_n) perm_prot |=> perm_prot)
    else $error("permanent flag dropped");
  rev_change_a: assert property (@(posedge link_clk) disable iff (!rst_n) $changed(rev_prot) |-> !standby)
    else $error("flag moved in standby");
endmodule

// *** dv/spd_bus_master.sv ***
`timescale 1ns/1ns
module spd_bus_master (
  input logic clk,
  input logic sda,
  output logic scl,
  output logic sda_oe_n
);
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic hp();
    repeat (10) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_oe_n <= b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda;
    scl <= 1'b0;
    hp();
  endtask
  task automatic start();
    sda_oe_n <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_oe_n <= 1'b0;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_oe_n <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_oe_n <= 1'b1;
    hp();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask
  // clock until the slave lets go of sda
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) begin
      bit_io(1'b1, r);
      if (r) break;
    end
  endtask
endmodule

// *** dv/spd_eeprom_serial_slave_front_end_tb_top.sv ***
`timescale 1ns/1ns
module spd_eeprom_serial_slave_front_end_tb_top;
  import spd_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic lock_i = 1'b0;
  logic [2:0] sel = 3'h0;
  logic scl, m_oe_n, sda_o, sda_oe_n, standby, write_busy, rev_prot, perm_prot;
  wire sda = m_oe_n & (sda_oe_n | sda_o);
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] mem_m [256];
  logic [7:0] ptr, q;
  logic ack;
  logic rev = 1'b0;
  logic perm = 1'b0;
  logic busy_seen = 1'b0;
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #15 link_clk = ~link_clk;
  end
  spd_eeprom_slave #(.WR_CYCLES(2000)) u_dut (.ref_clk, .rst_n, .link_clk, .scl_i(scl), .sda_i(sda), .sda_o,
    .sda_oe_n, .select_input_bit0(sel[0]), .select_input_bit1(sel[1]), .select_input_bit2(sel[2]), .lock_i,
    .standby, .write_busy, .rev_prot, .perm_prot);
  spd_bus_master u_mst (.clk(link_clk), .sda, .scl, .sda_oe_n(m_oe_n));
  always @(posedge ref_clk) if (write_busy === 1'b1) busy_seen <= 1'b1;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] sa, input logic exp);
    u_mst.start();
    u_mst.xfer(sa, 1'b1, q, ack);
    check(8'(ack), 8'(exp));
  endtask
  task automatic fin(input logic eb);
    u_mst.stop();
    if (eb) begin
      cmd({MEM_TYPE_CODE, sel, 1'b0}, 1'b1);
      u_mst.stop();
    end
    for (int i = 0; i < 3000 && standby !== 1'b1; i++) @(posedge link_clk);
    check(8'(standby), 8'h1);
    check(8'(busy_seen), 8'(eb));
  endtask
  task automatic wr(input logic [7:0] a, input int n);
    logic [7:0] d;
    logic wok;
    wok = 1'b0;
    busy_seen = 1'b0;
    cmd({MEM_TYPE_CODE, sel, 1'b0}, 1'b0);
    u_mst.xfer(a, 1'b1, q, ack);
    ptr = a;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      u_mst.xfer(d, 1'b1, q, ack);
      check(8'(ack), 8'h0);
      if (!lock_i && (ptr[7] || !(rev || perm))) begin
        mem_m[ptr] = d;
        wok = 1'b1;
      end
      ptr[3:0] = ptr[3:0] + 4'h1;
    end
    fin(wok);
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    busy_seen = 1'b0;
    cmd({MEM_TYPE_CODE, sel, 1'b0}, 1'b0);
    u_mst.xfer(a, 1'b1, q, ack);
    cmd({MEM_TYPE_CODE, sel, 1'b1}, 1'b0);
    ptr = a;
    for (int i = 1; i <= n; i++) begin
      u_mst.xfer(8'hff, i == n, q, ack);
      check(q, mem_m[ptr]);
      ptr++;
    end
    fin(1'b0);
  endtask
  task automatic prot(input logic [2:0] s, input logic rw, input logic exp);
    busy_seen = 1'b0;
    cmd({PROT_TYPE_CODE, s, rw}, exp);
    if (!rw && !exp) begin
      u_mst.xfer(8'h00, 1'b1, q, ack);
      u_mst.xfer(8'h00, 1'b1, q, ack);
    end
    fin(!rw && !exp);
  endtask
  task automatic results();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #760us;
    n_fail++;
    results();
  end
  initial begin
    void'($urandom(32'h4163a19f));
    @(posedge ref_clk);
    sel <= 3'($urandom_range(7, 4));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge link_clk);
    check(8'(standby), 8'h1);
    cmd({4'h5, sel, 1'b0}, 1'b1);
    cmd({MEM_TYPE_CODE, ~sel, 1'b0}, 1'b1);
    u_mst.stop();
    wr(8'h9e, 17);
    rd(8'h9c, 4);
    wr(8'h20, 1);
    @(posedge ref_clk);
    lock_i <= 1'b1;
    wr(8'h20, 1);
    @(posedge ref_clk);
    lock_i <= 1'b0;
    prot(SEL_SET_REV, 1'b1, 1'b0);
    prot(SEL_SET_REV, 1'b0, 1'b0);
    rev = 1'b1;
    check(8'(rev_prot), 8'h1);
    prot(SEL_CLR_REV, 1'b1, 1'b1);
    wr(8'h20, 1);
    prot(SEL_CLR_REV, 1'b0, 1'b0);
    rev = 1'b0;
    check(8'(rev_prot), 8'h0);
    prot(sel, 1'b1, 1'b0);
    prot(sel, 1'b0, 1'b0);
    perm = 1'b1;
    check(8'(perm_prot), 8'h1);
    prot(SEL_SET_REV, 1'b0, 1'b1);
    wr(8'h20, 1);
    // a write into the upper half cut short by a start must leave the array untouched
    u_mst.start();
    u_mst.xfer({MEM_TYPE_CODE, sel, 1'b0}, 1'b1, q, ack);
    u_mst.xfer(8'h9e, 1'b1, q, ack);
    u_mst.xfer(~mem_m[8'h9e], 1'b1, q, ack);
    u_mst.bit_io(1'b0, ack);
    u_mst.recover();
    rd(8'h9e, 1);
    rd(8'h20, 1);
    results();
  end
endmodule
bind spd_eeprom_slave spd_slave_props #(.WR_CYCLES(WR_CYCLES)) u_props (.ref_clk, .rst_n, .link_clk, .scl_i,
  .sda_o, .sda_oe_n, .lock_i, .standby, .write_busy, .rev_prot, .perm_prot);
